// ==== shared/dpat_params.svh ====
// constants of the data page address translation block
`ifndef DPAT_PARAMS_SVH
`define DPAT_PARAMS_SVH

`define DPAT_NUM_PSEL        4
`define DPAT_PN_WIDTH        10
`define DPAT_PN_LSB          0
`define DPAT_OFS_WIDTH       14
`define DPAT_NSEG_PN_WIDTH   2
`define DPAT_SEG_WIDTH       8
`define DPAT_PSEL0_OFFSET    16'hfe00
`define DPAT_PSEL1_OFFSET    16'hfe02
`define DPAT_PSEL2_OFFSET    16'hfe04
`define DPAT_PSEL3_OFFSET    16'hfe06
`define DPAT_PSEL_SPAN       16'h0008
`define DPAT_PSEL0_RESET     16'h0000
`define DPAT_PSEL1_RESET     16'h0001
`define DPAT_PSEL2_RESET     16'h0002
`define DPAT_PSEL3_RESET     16'h0003

`endif

// ==== shared/dpat_pkg.sv ====
// types and decode helpers of the data page address translation block
`include "dpat_params.svh"

package dpat_pkg;

   typedef logic [15:0]                     dpat_word_t;
   typedef logic [`DPAT_PN_WIDTH-1:0]       dpat_page_t;
   typedef logic [`DPAT_OFS_WIDTH-1:0]      dpat_ofs_t;
   typedef logic [23:0]                     dpat_phys_t;
   typedef logic [1:0]                      dpat_sel_t;
   typedef logic [`DPAT_SEG_WIDTH-1:0]      dpat_seg_t;

   // true when the word address falls on one of the page select registers
   function automatic logic dpat_psel_hit(input dpat_word_t addr);
      dpat_word_t d;
      d = addr - `DPAT_PSEL0_OFFSET;
      return (d < `DPAT_PSEL_SPAN) && !d[0];
   endfunction

   // register index of a page select address
   function automatic dpat_sel_t dpat_psel_index(input dpat_word_t addr);
      dpat_word_t d;
      d = addr - `DPAT_PSEL0_OFFSET;
      return d[2:1];
   endfunction

   // reset contents of page select register n
   function automatic dpat_page_t dpat_psel_reset(input dpat_sel_t n);
      dpat_word_t v;
      case (n)
         2'h0:    v = `DPAT_PSEL0_RESET;
         2'h1:    v = `DPAT_PSEL1_RESET;
         2'h2:    v = `DPAT_PSEL2_RESET;
         default: v = `DPAT_PSEL3_RESET;
      endcase
      return v[`DPAT_PN_WIDTH-1:0];
   endfunction

endpackage

// ==== rtl/dpat_regs.sv ====
// page select register file written through the special function register port
`timescale 1ns/1ps
`include "dpat_params.svh"

module dpat_regs #(
   parameter int NUM = `DPAT_NUM_PSEL
) (
   input  wire logic                           clock,
   input  wire logic                           rst_n,
   input  wire logic                           wr_en,
   input  wire dpat_pkg::dpat_word_t           wr_addr,
   input  wire dpat_pkg::dpat_word_t           wr_data,
   output dpat_pkg::dpat_page_t                pages [NUM]
);

   dpat_pkg::dpat_page_t page_q    [NUM];
   dpat_pkg::dpat_page_t next_page [NUM];

   always_comb begin
      for (int i = 0; i < NUM; i++) begin
         next_page[i] = page_q[i];
      end
      // only special function register writes to a page select address reach these
      if (wr_en && dpat_pkg::dpat_psel_hit(wr_addr)) begin
         // only the page number field is stored; upper bits dropped
         next_page[dpat_pkg::dpat_psel_index(wr_addr)] =
            wr_data[`DPAT_PN_LSB +: `DPAT_PN_WIDTH];
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM; i++) begin
            page_q[i] <= dpat_pkg::dpat_psel_reset(2'(i));
         end
      end else begin
         for (int i = 0; i < NUM; i++) begin
            page_q[i] <= next_page[i];
         end
      end
   end

   assign pages = page_q;

endmodule // dpat_regs

// ==== rtl/dpat_top.sv ====
// data page and code address translation of the core
`timescale 1ns/1ps
`include "dpat_params.svh"

//  Function
// - four page select registers each hold a ten bit number choosing one of 1024 16 KB pages.
// - the upper six bits of each page select register have no page function.
// - after reset register n holds n so long addresses map one to one onto pages 0 to 3.
// - the top two bits of a data address choose which page select register is used.
// - the physical 24 bit address is the chosen page number above the low 14 address bits.
// - in non-segmented mode only the low two page number bits take part in the address.
// - long data accesses are translated, override and event transfer accesses are not.
// - a page value written does not steer the address of the access issued with the write.
// - only a special function register write to a page select address writes a page select register.
// - with segmentation off the instruction pointer is the code address unchanged.
// - with segmentation off code fetches stay in segment zero whatever the segment holds.
module dpat_top (
   input  wire logic                    clock,
   input  wire logic                    arst_n,
   // special function register port
   input  wire logic                    sfr_wr_en,
   input  wire logic                    sfr_rd_en,
   input  wire dpat_pkg::dpat_word_t    sfr_addr,
   input  wire dpat_pkg::dpat_word_t    sfr_wdata,
   output dpat_pkg::dpat_word_t         sfr_rdata,
   output logic                         sfr_rd_valid,
   output logic                         sfr_rd_hit,
   // mode from the core
   input  wire logic                    segmented,
   // data access request
   input  wire logic                    data_valid,
   input  wire dpat_pkg::dpat_word_t    data_addr,
   input  wire logic                    bypass,
   input  wire dpat_pkg::dpat_page_t    bypass_page,
   output dpat_pkg::dpat_phys_t         phys_addr,
   output logic                         phys_valid,
   // code fetch request
   input  wire logic                    fetch_valid,
   input  wire dpat_pkg::dpat_word_t    instruction_pointer,
   input  wire dpat_pkg::dpat_seg_t     code_segment_register,
   output dpat_pkg::dpat_phys_t         code_addr,
   output logic                         code_valid
);

   logic                  rst_meta;
   logic                  rst_n;
   dpat_pkg::dpat_page_t  pages [`DPAT_NUM_PSEL];

   dpat_pkg::dpat_word_t  next_sfr_rdata;
   logic                  next_sfr_rd_valid;
   logic                  next_sfr_rd_hit;
   dpat_pkg::dpat_phys_t  next_phys_addr;
   logic                  next_phys_valid;
   dpat_pkg::dpat_phys_t  next_code_addr;
   logic                  next_code_valid;

   dpat_pkg::dpat_sel_t   sel;
   dpat_pkg::dpat_page_t  cur_page;
   dpat_pkg::dpat_page_t  eff_page;

   // reset release synchronised; assertion stays asynchronous
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   dpat_regs #(
      .NUM (`DPAT_NUM_PSEL)
   ) u_regs (
      .clock   (clock),
      .rst_n   (rst_n),
      .wr_en   (sfr_wr_en),
      .wr_addr (sfr_addr),
      .wr_data (sfr_wdata),
      .pages   (pages)
   );

   // register read-back, one cycle latency
   always_comb begin
      next_sfr_rdata    = 16'h0000;
      next_sfr_rd_valid = sfr_rd_en;
      next_sfr_rd_hit   = 1'b0;
      if (sfr_rd_en && dpat_pkg::dpat_psel_hit(sfr_addr)) begin
         next_sfr_rd_hit = 1'b1;
         // reserved bits return zero
         next_sfr_rdata = 16'(pages[dpat_pkg::dpat_psel_index(sfr_addr)]);
      end
   end

   // page selection from the top two address bits
   assign sel      = data_addr[15:14];
   assign cur_page = pages[sel];

   // registered pages only: a write in this cycle lands after the edge
   always_comb begin
      if (segmented) begin
         eff_page = cur_page;
      end else begin
         // mode reduces the page to its low two bits
         eff_page = {{(`DPAT_PN_WIDTH-`DPAT_NSEG_PN_WIDTH){1'b0}},
                     cur_page[`DPAT_NSEG_PN_WIDTH-1:0]};
      end
   end

   always_comb begin
      next_phys_valid = data_valid;
      next_phys_addr  = 24'h00_0000;
      if (data_valid) begin
         if (bypass) begin
            // override and event transfers carry their own page
            next_phys_addr = {bypass_page, data_addr[`DPAT_OFS_WIDTH-1:0]};
         end else begin
            next_phys_addr = {eff_page, data_addr[`DPAT_OFS_WIDTH-1:0]};
         end
      end
   end

   always_comb begin
      next_code_valid = fetch_valid;
      next_code_addr  = 24'h00_0000;
      if (fetch_valid) begin
         if (segmented) begin
            next_code_addr = {code_segment_register, instruction_pointer};
         end else begin
            // segment forced to zero, pointer used as is
            next_code_addr = {8'h00, instruction_pointer};
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata    <= 16'h0000;
         sfr_rd_valid <= 1'b0;
         sfr_rd_hit   <= 1'b0;
         phys_addr    <= 24'h00_0000;
         phys_valid   <= 1'b0;
         code_addr    <= 24'h00_0000;
         code_valid   <= 1'b0;
      end else begin
         sfr_rdata    <= next_sfr_rdata;
         sfr_rd_valid <= next_sfr_rd_valid;
         sfr_rd_hit   <= next_sfr_rd_hit;
         phys_addr    <= next_phys_addr;
         phys_valid   <= next_phys_valid;
         code_addr    <= next_code_addr;
         code_valid   <= next_code_valid;
      end
   end

   // checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_reset_identity: assert property (
      $rose(rst_n) |-> (pages[0] == 10'h000) && (pages[1] == 10'h001)
                       && (pages[2] == 10'h002) && (pages[3] == 10'h003))
      else $error("page select reset values wrong");

   a_page_select: assert property (
      data_valid && !bypass && segmented
      |=> phys_addr[23:14] == $past(pages[data_addr[15:14]]))
      else $error("wrong page select register used");

   a_offset_kept: assert property (
      data_valid |=> phys_valid && (phys_addr[13:0] == $past(data_addr[13:0])))
      else $error("page offset not preserved");

   a_nonseg_page: assert property (
      data_valid && !bypass && !segmented
      |=> (phys_addr[23:16] == 8'h00)
          && (phys_addr[15:14] == $past(cur_page[1:0])))
      else $error("non-segmented page not reduced");

   a_bypass_page: assert property (
      data_valid && bypass |=> phys_addr[23:14] == $past(bypass_page))
      else $error("override access translated");

   a_write_late: assert property (
      sfr_wr_en && dpat_pkg::dpat_psel_hit(sfr_addr) && data_valid && !bypass
      && segmented && (dpat_pkg::dpat_psel_index(sfr_addr) == sel)
      && (sfr_wdata[9:0] != cur_page)
      |=> phys_addr[23:14] != $past(sfr_wdata[9:0]))
      else $error("new page used by same access");

   a_write_lands: assert property (
      sfr_wr_en && dpat_pkg::dpat_psel_hit(sfr_addr)
      |=> pages[$past(dpat_pkg::dpat_psel_index(sfr_addr))] == $past(sfr_wdata[9:0]))
      else $error("page select write lost");

   a_reserved_zero: assert property (
      sfr_rd_en |=> sfr_rd_valid && (sfr_rdata[15:10] == 6'h00))
      else $error("reserved bits not zero");

   // unmapped reads answer but must not leak a page value
   a_unmapped_read: assert property (
      sfr_rd_en && !dpat_pkg::dpat_psel_hit(sfr_addr)
      |=> sfr_rd_valid && !sfr_rd_hit && (sfr_rdata == 16'h0000))
      else $error("unmapped read not zero");

   a_code_nonseg: assert property (
      fetch_valid && !segmented |=> code_addr == {8'h00, $past(instruction_pointer)})
      else $error("non-segmented code address wrong");

   a_code_seg: assert property (
      fetch_valid && segmented
      |=> code_addr[23:16] == $past(code_segment_register))
      else $error("segmented code address wrong");

   c_seg_access: cover property (data_valid && segmented && !bypass && sel == 2'h3);
   c_nonseg_access: cover property (data_valid && !segmented && !bypass);
   c_write_then_use: cover property (sfr_wr_en && dpat_pkg::dpat_psel_hit(sfr_addr)
                                     ##1 data_valid && !bypass);
   c_bypass: cover property (data_valid && bypass);

endmodule // dpat_top

// ==== tb/dpat_top_tb.sv ====
// self-checking bench of the data page address translation block
`timescale 1ns/1ps

module dpat_top_tb;
   logic                 clock                 = 1'h0;
   logic                 arst_n                = 1'h0;
   logic                 sfr_wr_en             = 1'h0;
   logic                 sfr_rd_en             = 1'h0;
   dpat_pkg::dpat_word_t sfr_addr              = 16'h0000;
   dpat_pkg::dpat_word_t sfr_wdata             = 16'h0000;
   dpat_pkg::dpat_word_t sfr_rdata;
   logic                 sfr_rd_valid;
   logic                 sfr_rd_hit;
   logic                 segmented             = 1'h1;
   logic                 data_valid            = 1'h0;
   dpat_pkg::dpat_word_t data_addr             = 16'h0000;
   logic                 bypass                = 1'h0;
   dpat_pkg::dpat_page_t bypass_page           = 10'h000;
   dpat_pkg::dpat_phys_t phys_addr;
   logic                 phys_valid;
   logic                 fetch_valid           = 1'h0;
   dpat_pkg::dpat_word_t instruction_pointer   = 16'h0000;
   dpat_pkg::dpat_seg_t  code_segment_register = 8'h00;
   dpat_pkg::dpat_phys_t code_addr;
   logic                 code_valid;
   int                   n_fail                = 0;
   int                   check_count           = 0;
   int                   cycles                = 0;

   dpat_top dpat_top_i (
      .clock, .arst_n, .sfr_wr_en, .sfr_rd_en, .sfr_addr, .sfr_wdata, .sfr_rdata,
      .sfr_rd_valid, .sfr_rd_hit, .segmented, .data_valid, .data_addr, .bypass,
      .bypass_page, .phys_addr, .phys_valid, .fetch_valid, .instruction_pointer,
      .code_segment_register, .code_addr, .code_valid
   );

   always #5 clock = ~clock;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // a hung handshake ends the run here
   always @(posedge clock) begin
      cycles++;
      if (cycles == 2000) begin
         n_fail++;
         end_sim();
      end
   end

   task automatic check(input logic [24:0] seen, input logic [24:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clock);
      sfr_wr_en <= 1'h1;
      sfr_addr  <= a;
      sfr_wdata <= d;
      @(posedge clock);
      sfr_wr_en <= 1'h0;
   endtask

   task automatic rd(input logic [15:0] a, output logic [24:0] q);
      @(posedge clock);
      sfr_rd_en <= 1'h1;
      sfr_addr  <= a;
      @(posedge clock);
      sfr_rd_en <= 1'h0;
      #1;
      q = {7'h00, sfr_rd_valid, sfr_rd_hit, sfr_rdata};
   endtask

   task automatic acc(input logic [15:0] a, input logic s, input logic b,
                      output logic [24:0] q);
      @(posedge clock);
      data_valid <= 1'h1;
      data_addr  <= a;
      segmented  <= s;
      bypass     <= b;
      @(posedge clock);
      data_valid <= 1'h0;
      #1;
      q = {phys_valid, phys_addr};
   endtask

   task automatic fetch(input logic [15:0] a, input logic [7:0] cs, input logic s,
                        output logic [24:0] q);
      @(posedge clock);
      fetch_valid           <= 1'h1;
      instruction_pointer   <= a;
      code_segment_register <= cs;
      segmented             <= s;
      @(posedge clock);
      fetch_valid <= 1'h0;
      #1;
      q = {code_valid, code_addr};
   endtask

   task automatic t_reset();
      logic [24:0] q;
      logic [1:0]  k;
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         rd(16'hfe00 + 16'(2 * i), q);
         check(q, {7'h00, 1'h1, 1'h1, 14'h0000, k});
         acc({k, 14'h1abc}, 1'h1, 1'h0, q);
         check(q, {1'h1, 8'h00, k, 14'h1abc});
      end
      $display("t_reset done");
   endtask

   // write and access in one cycle: the access must still see the old page
   task automatic t_order();
      @(posedge clock);
      sfr_wr_en  <= 1'h1;
      sfr_addr   <= 16'hfe06;
      sfr_wdata  <= 16'h0155;
      data_valid <= 1'h1;
      data_addr  <= 16'hc001;
      segmented  <= 1'h1;
      bypass     <= 1'h0;
      @(posedge clock);
      sfr_wr_en <= 1'h0;
      data_addr <= 16'hc002;
      #1;
      check({phys_valid, phys_addr}, {1'h1, 10'h003, 14'h0001});
      @(posedge clock);
      data_valid <= 1'h0;
      #1;
      check({phys_valid, phys_addr}, {1'h1, 10'h155, 14'h0002});
      $display("t_order done");
   endtask

   task automatic t_write();
      logic [24:0] q;
      logic [1:0]  k;
      for (int i = 0; i < 4; i++)
         // low page bits differ from the selecting address bits
         wr(16'hfe00 + 16'(2 * i), {6'h3f, 8'h5a, ~2'(i)});
      // odd and unmapped places must leave everything alone
      wr(16'hfe03, 16'h0000);
      wr(16'hfe08, 16'h0000);
      rd(16'hfe08, q);
      check(q, {7'h00, 1'h1, 1'h0, 16'h0000});
      for (int i = 0; i < 4; i++) begin
         k = 2'(i);
         rd(16'hfe00 + 16'(2 * i), q);
         check(q, {7'h00, 1'h1, 1'h1, 6'h00, 8'h5a, ~k});
         acc({k, 14'h2a5a}, 1'h1, 1'h0, q);
         check(q, {1'h1, 8'h5a, ~k, 14'h2a5a});
         acc({k, 14'h0fff}, 1'h0, 1'h0, q);
         check(q, {1'h1, 8'h00, ~k, 14'h0fff});
      end
      $display("t_write done");
   endtask

   task automatic t_bypass();
      logic [24:0] q;
      @(posedge clock);
      bypass_page <= 10'h2c7;
      acc(16'h4321, 1'h1, 1'h1, q);
      check(q, {1'h1, 10'h2c7, 14'h0321});
      acc(16'hc321, 1'h0, 1'h1, q);
      check(q, {1'h1, 10'h2c7, 14'h0321});
      $display("t_bypass done");
   endtask

   task automatic t_code();
      logic [24:0] q;
      fetch(16'h1234, 8'h05, 1'h0, q);
      check(q, {1'h1, 8'h00, 16'h1234});
      fetch(16'hbeef, 8'h5a, 1'h1, q);
      check(q, {1'h1, 8'h5a, 16'hbeef});
      $display("t_code done");
   endtask

   // written pages must fall back to their reset values on a second reset
   task automatic t_rst_again();
      @(posedge clock);
      arst_n <= 1'h0;
      repeat (2) @(posedge clock);
      arst_n <= 1'h1;
      repeat (3) @(posedge clock);
      t_reset();
      $display("t_rst_again done");
   endtask

   initial begin
      repeat (2) @(posedge clock);
      arst_n <= 1'h1;
      // two sync flops inside, first request no earlier than the third edge
      repeat (3) @(posedge clock);
      t_reset();
      t_order();
      t_write();
      t_bypass();
      t_code();
      t_rst_again();
      end_sim();
   end
endmodule // dpat_top_tb
